// *** node_processor_register_port.sv ***
// register port of the line controller: register file, counters, pins
`timescale 1ns/1ps
// How it works
// - unknown-state pin follows the unknown-state flag of status_a.
// - scrambling on when pin high, else control_c bit 0 decides.
// - all port signals sampled on rising edge of the port clock.
// - reads change nothing except clearing event flags and three counters.
// - first edge seeing select low samples address and read/write line.
// - data bus driven no sooner than half a clock after that edge.
// - read data valid from second edge until second edge after deselect.
// - bus released within half a clock after that second edge.
// - each later edge still seeing select low extends valid data one period.
// - bad or ill-timed writes set host-error flag, register unchanged.
// - one register write per selection; deselect has no other effect.
// - twenty-seven 16-bit registers at word addresses 00 to 1a.
// - vector writes need idle signalling; timer loads need service state.
// - control_a readable, writable and fully cleared by reset.
// - guarded control_a bits change only in off or service state.
// - interrupt output stays low until event flags are read.
module node_processor_register_port (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic i_cs_n,
   input wire logic [host_port_pkg::ADDR_W-1:0] i_host_address_bus,
   input wire logic i_host_read_write,
   input wire logic [host_port_pkg::DATA_W-1:0] i_host_data_bus,
   output logic [host_port_pkg::DATA_W-1:0] o_host_data_bus,
   output logic o_host_data_bus_en_n,
   output logic o_irq_n,
   input wire logic i_scrambler_enable_pin,
   output logic o_scrambler_on,
   output logic o_unknown_state_pin,
   input wire logic [host_port_pkg::CONN_W-1:0] i_conn_state,
   input wire logic [host_port_pkg::DATA_W-1:0] i_status_a,
   input wire logic [host_port_pkg::DATA_W-1:0] i_status_b,
   input wire logic [host_port_pkg::DATA_W-1:0] i_period_timer_value,
   input wire logic [host_port_pkg::DATA_W-1:0] i_noise_timer_value,
   input wire logic [host_port_pkg::DATA_W-1:0] i_clock_divider_value,
   input wire logic [host_port_pkg::DATA_W-1:0] i_self_test_result,
   input wire logic [host_port_pkg::DATA_W-1:0] i_received_signal_bits,
   input wire logic [host_port_pkg::DATA_W-1:0] i_event_set,
   input wire logic [host_port_pkg::NUM_CTR-1:0] i_count_inc,
   output logic [host_port_pkg::DATA_W-1:0] o_control_a,
   output logic [host_port_pkg::DATA_W-1:0] o_control_b,
   output logic [host_port_pkg::DATA_W-1:0] o_control_c,
   output logic [host_port_pkg::DATA_W-1:0] o_period_timer_load,
   output logic o_period_timer_load_stb,
   output logic [host_port_pkg::DATA_W-1:0] o_noise_timer_load,
   output logic o_noise_timer_load_stb
);
   import host_port_pkg::*;

   logic start;
   logic write_edge;
   logic in_access;
   logic in_tail;
   logic finish;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] rw_regs_q [NUM_RW];
   logic [DATA_W-1:0] event_flags_q;
   logic [DATA_W-1:0] counts_q [NUM_CTR];
   logic [DATA_W-1:0] read_word;
   logic scram_meta_q;
   logic scram_sync_q;
   logic service_state;
   logic conn_quiet;
   logic signalling_active_flag;
   logic write_ok;
   logic write_err;
   logic read_events;
   logic [NUM_CTR-1:0] read_count;

   // sequencing of each host cycle
   host_cycle_ctrl u_cycle (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_clk_en(i_clk_en),
      .i_cs_n(i_cs_n),
      .i_read(i_host_read_write),
      .o_start(start),
      .o_write_edge(write_edge),
      .o_access(in_access),
      .o_tail(in_tail),
      .o_finish(finish)
   );

   // address latched at the edge where select is first seen
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         addr_q <= ADDR_CONTROL_A;
      end else if (i_clk_en && start) begin
         addr_q <= i_host_address_bus;
      end
   end

   assign service_state = (i_conn_state == CONN_SERVICE);
   assign conn_quiet = (i_conn_state == CONN_OFF) || service_state;
   assign signalling_active_flag = i_status_b[SIGNALLING_ACTIVE_BIT];

   // write permission per address; unmapped addresses count as read-only
   always_comb begin
      write_ok = 1'b0;
      if (addr_q <= ADDR_NOISE_LIMIT) begin
         write_ok = 1'b1;
         if (addr_q == ADDR_TRANSMIT_SIGNAL_BITS || addr_q == ADDR_SIGNAL_BITS_COUNT) begin
            write_ok = !signalling_active_flag;
         end
      end else if (addr_q == ADDR_PERIOD_TIMER_LOAD) begin
         write_ok = service_state;
      end else if (addr_q == ADDR_NOISE_TIMER_LOAD) begin
         write_ok = service_state && !rw_regs_q[0][NOISE_TIMER_BIT];
      end
   end

   assign write_err = write_edge && !write_ok;

   // clear-on-read strobes taken at the sampling edge of a read
   assign read_events = start && i_host_read_write && (i_host_address_bus == ADDR_EVENT_FLAGS);

   // read-write registers; control_a guarded bits need a quiet connection
   for (genvar r = 0; r < NUM_RW; r++) begin : g_rw
      logic [DATA_W-1:0] keep_mask;
      assign keep_mask = (r == 0) ? (conn_quiet ? ZERO_WORD : CONTROL_A_GUARDED) : ZERO_WORD;
      always_ff @(posedge i_clk or posedge i_sys_rst) begin
         if (i_sys_rst) begin
            rw_regs_q[r] <= ZERO_WORD;
         end else if (i_clk_en && write_edge && write_ok && addr_q == ADDR_W'(r)) begin
            rw_regs_q[r] <= ((i_host_data_bus & ~keep_mask) | (rw_regs_q[r] & keep_mask))
               & ((r == 0) ? CONTROL_A_USED : FULL_WORD);
         end
      end
   end

   // timer load words and one-cycle load strobes
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_period_timer_load <= ZERO_WORD;
         o_period_timer_load_stb <= 1'b0;
         o_noise_timer_load <= ZERO_WORD;
         o_noise_timer_load_stb <= 1'b0;
      end else if (i_clk_en) begin
         o_period_timer_load_stb <= 1'b0;
         o_noise_timer_load_stb <= 1'b0;
         if (write_edge && write_ok && addr_q == ADDR_PERIOD_TIMER_LOAD) begin
            o_period_timer_load <= i_host_data_bus;
            o_period_timer_load_stb <= 1'b1;
         end
         if (write_edge && write_ok && addr_q == ADDR_NOISE_TIMER_LOAD) begin
            o_noise_timer_load <= i_host_data_bus;
            o_noise_timer_load_stb <= 1'b1;
         end
      end
   end

   // sticky events; a new event in the clearing cycle survives
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         event_flags_q <= ZERO_WORD;
      end else if (i_clk_en) begin
         event_flags_q <= (read_events ? ZERO_WORD : event_flags_q) | i_event_set;
         if (write_err) begin
            event_flags_q[HOST_ERROR_BIT] <= 1'b1;
         end
      end
   end

   // error and gap counters, saturating, cleared when read
   for (genvar c = 0; c < NUM_CTR; c++) begin : g_ctr
      assign read_count[c] = start && i_host_read_write
         && (i_host_address_bus == ADDR_BAD_SYMBOL_COUNT + ADDR_W'(c));
      always_ff @(posedge i_clk or posedge i_sys_rst) begin
         if (i_sys_rst) begin
            counts_q[c] <= ZERO_WORD;
         end else if (i_clk_en) begin
            if (read_count[c]) begin
               counts_q[c] <= i_count_inc[c] ? ONE_WORD : ZERO_WORD;
            end else if (i_count_inc[c] && counts_q[c] != FULL_WORD) begin
               counts_q[c] <= counts_q[c] + ONE_WORD;
            end
         end
      end

      property p_count_clear;
         @(posedge i_clk) disable iff (i_sys_rst)
         (i_clk_en && read_count[c] && !i_count_inc[c]) |=> counts_q[c] == ZERO_WORD;
      endproperty
      a_count_clear: assert property (p_count_clear) else $error("count not cleared");
   end

   // read multiplexer on the live address; write-only words read zero
   always_comb begin
      read_word = ZERO_WORD;
      if (i_host_address_bus <= ADDR_NOISE_LIMIT) begin
         read_word = rw_regs_q[i_host_address_bus[3:0]];
      end else begin
         case (i_host_address_bus)
            ADDR_STATUS_A: read_word = i_status_a;
            ADDR_STATUS_B: read_word = i_status_b;
            ADDR_PERIOD_TIMER_VALUE: read_word = i_period_timer_value;
            ADDR_NOISE_TIMER_VALUE: read_word = i_noise_timer_value;
            ADDR_CLOCK_DIVIDER_VALUE: read_word = i_clock_divider_value;
            ADDR_SELF_TEST_RESULT: read_word = i_self_test_result;
            ADDR_RECEIVED_SIGNAL_BITS: read_word = i_received_signal_bits;
            ADDR_EVENT_FLAGS: read_word = event_flags_q;
            ADDR_BAD_SYMBOL_COUNT: read_word = counts_q[0];
            ADDR_SHORT_GAP_COUNT: read_word = counts_q[1];
            ADDR_LINK_FAULT_COUNT: read_word = counts_q[2];
            default: read_word = ZERO_WORD;
         endcase
      end
   end

   // bus drive begins after the sampling edge, so the old driver has let go
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_host_data_bus <= ZERO_WORD;
         o_host_data_bus_en_n <= 1'b1;
      end else if (i_clk_en) begin
         if (start && i_host_read_write) begin
            o_host_data_bus <= read_word;
            o_host_data_bus_en_n <= 1'b0;
         end else if (finish) begin
            o_host_data_bus_en_n <= 1'b1;
         end
      end
   end

   // pin synchroniser and output pins
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         scram_meta_q <= 1'b0;
         scram_sync_q <= 1'b0;
         o_scrambler_on <= 1'b0;
         o_unknown_state_pin <= 1'b0;
         o_irq_n <= 1'b1;
      end else if (i_clk_en) begin
         scram_meta_q <= i_scrambler_enable_pin;
         scram_sync_q <= scram_meta_q;
         o_scrambler_on <= scram_sync_q || rw_regs_q[10][SCRAMBLE_CTRL_BIT];
         o_unknown_state_pin <= i_status_a[UNKNOWN_STATE_BIT];
         o_irq_n <= !(|(event_flags_q & rw_regs_q[2]));
      end
   end

   assign o_control_a = rw_regs_q[0];
   assign o_control_b = rw_regs_q[1];
   assign o_control_c = rw_regs_q[10];

   // checks
   sequence s_read_start;
      i_clk_en && start && i_host_read_write;
   endsequence

   property p_unknown_pin;
      @(posedge i_clk) disable iff (i_sys_rst)
      i_clk_en |=> o_unknown_state_pin == $past(i_status_a[UNKNOWN_STATE_BIT]);
   endproperty
   a_unknown_pin: assert property (p_unknown_pin) else $error("unknown pin wrong");

   property p_scrambler;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_clk_en && rw_regs_q[10][SCRAMBLE_CTRL_BIT]) |=> o_scrambler_on;
   endproperty
   a_scrambler: assert property (p_scrambler) else $error("scrambler not on");

   property p_read_drive;
      @(posedge i_clk) disable iff (i_sys_rst)
      s_read_start |=> !o_host_data_bus_en_n && o_host_data_bus == $past(read_word);
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("read data not driven");

   property p_release;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_clk_en && in_tail) |=> o_host_data_bus_en_n;
   endproperty
   a_release: assert property (p_release) else $error("bus not released");

   property p_extend;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_clk_en && in_access && !o_host_data_bus_en_n && !i_cs_n) |=> !o_host_data_bus_en_n [*2];
   endproperty
   a_extend: assert property (p_extend) else $error("read not extended");

   property p_events_clear;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_clk_en && read_events && !write_err) |=> event_flags_q == $past(i_event_set);
   endproperty
   a_events_clear: assert property (p_events_clear) else $error("events not cleared");

   property p_one_write;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_clk_en && write_edge) |=> !write_edge throughout (!start [*2]);
   endproperty
   a_one_write: assert property (p_one_write) else $error("second write");

   property p_host_error;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_clk_en && write_err) |=> event_flags_q[HOST_ERROR_BIT];
   endproperty
   a_host_error: assert property (p_host_error) else $error("host error not set");

   property p_guarded;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_clk_en && !conn_quiet) |=>
         (rw_regs_q[0] & CONTROL_A_GUARDED) == $past(rw_regs_q[0] & CONTROL_A_GUARDED);
   endproperty
   a_guarded: assert property (p_guarded) else $error("guarded bit changed");

   property p_irq_hold;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_clk_en && |(event_flags_q & rw_regs_q[2]) && !read_events) |=> !o_irq_n;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");

   // refused writes must not strobe a timer load
   sequence s_bad_write;
      i_clk_en && write_err;
   endsequence

   property p_no_load;
      @(posedge i_clk) disable iff (i_sys_rst)
      s_bad_write |=> !o_period_timer_load_stb && !o_noise_timer_load_stb;
   endproperty
   a_no_load: assert property (p_no_load) else $error("refused write loaded");

   // old driver gets the sampling cycle to let go
   property p_late_drive;
      @(posedge i_clk) disable iff (i_sys_rst)
      s_read_start |-> o_host_data_bus_en_n;
   endproperty
   a_late_drive: assert property (p_late_drive) else $error("drove too early");

   // enable low holds the state still
   property p_freeze;
      @(posedge i_clk) disable iff (i_sys_rst)
      !i_clk_en |=> $stable(counts_q[2]) && $stable(o_irq_n);
   endproperty
   a_freeze: assert property (p_freeze) else $error("moved while frozen");
endmodule

// *** host_port_pkg.sv ***
// shared constants for the node processor register port
package host_port_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int NUM_RW = 14;
   localparam int NUM_CTR = 3;
   localparam int CONN_W = 4;

   // register word addresses
   localparam logic [4:0] ADDR_CONTROL_A = 5'h00;
   localparam logic [4:0] ADDR_CONTROL_B = 5'h01;
   localparam logic [4:0] ADDR_INTERRUPT_ENABLE_MASK = 5'h02;
   localparam logic [4:0] ADDR_TRANSMIT_SIGNAL_BITS = 5'h03;
   localparam logic [4:0] ADDR_SIGNAL_BITS_COUNT = 5'h04;
   localparam logic [4:0] ADDR_ERROR_LIMIT = 5'h05;
   localparam logic [4:0] ADDR_CONNECT_MIN_TIME = 5'h06;
   localparam logic [4:0] ADDR_LINE_STATE_MIN_TIME = 5'h07;
   localparam logic [4:0] ADDR_BREAK_MIN_TIME = 5'h08;
   localparam logic [4:0] ADDR_TIMEOUT_VALUE = 5'h09;
   localparam logic [4:0] ADDR_CONTROL_C = 5'h0a;
   localparam logic [4:0] ADDR_CONFIDENCE_TEST_LENGTH = 5'h0b;
   localparam logic [4:0] ADDR_CLEANUP_TIME = 5'h0c;
   localparam logic [4:0] ADDR_NOISE_LIMIT = 5'h0d;
   localparam logic [4:0] ADDR_PERIOD_TIMER_LOAD = 5'h0e;
   localparam logic [4:0] ADDR_NOISE_TIMER_LOAD = 5'h0f;
   localparam logic [4:0] ADDR_STATUS_A = 5'h10;
   localparam logic [4:0] ADDR_STATUS_B = 5'h11;
   localparam logic [4:0] ADDR_PERIOD_TIMER_VALUE = 5'h12;
   localparam logic [4:0] ADDR_NOISE_TIMER_VALUE = 5'h13;
   localparam logic [4:0] ADDR_CLOCK_DIVIDER_VALUE = 5'h14;
   localparam logic [4:0] ADDR_SELF_TEST_RESULT = 5'h15;
   localparam logic [4:0] ADDR_RECEIVED_SIGNAL_BITS = 5'h16;
   localparam logic [4:0] ADDR_EVENT_FLAGS = 5'h17;
   localparam logic [4:0] ADDR_BAD_SYMBOL_COUNT = 5'h18;
   localparam logic [4:0] ADDR_SHORT_GAP_COUNT = 5'h19;
   localparam logic [4:0] ADDR_LINK_FAULT_COUNT = 5'h1a;

   // field positions
   localparam int UNKNOWN_STATE_BIT = 8;
   localparam int SIGNALLING_ACTIVE_BIT = 8;
   localparam int HOST_ERROR_BIT = 0;
   localparam int SCRAMBLE_CTRL_BIT = 0;
   localparam int NOISE_TIMER_BIT = 14;
   // control_a bits writable only in off or service state
   localparam logic [15:0] CONTROL_A_GUARDED = 16'h3000;
   // reserved top bit of control_a reads zero
   localparam logic [15:0] CONTROL_A_USED = 16'h7fff;

   // connection management state codes seen on i_conn_state
   localparam logic [3:0] CONN_OFF = 4'h0;
   localparam logic [3:0] CONN_SERVICE = 4'h9;

   localparam logic [15:0] ZERO_WORD = 16'h0000;
   localparam logic [15:0] ONE_WORD = 16'h0001;
   localparam logic [15:0] FULL_WORD = 16'hffff;
endpackage

// *** host_cycle_ctrl.sv ***
// cycle sequencer for the synchronous host port: start, write edge, tail
`timescale 1ns/1ps
module host_cycle_ctrl (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic i_cs_n,
   input wire logic i_read,
   output logic o_start,
   output logic o_write_edge,
   output logic o_access,
   output logic o_tail,
   output logic o_finish
);
   import host_port_pkg::*;

   typedef enum logic [1:0] {
      IDLE,
      ACCESS,
      TAIL
   } cycle_state_t;

   cycle_state_t state_q;
   logic first_q;
   logic read_q;

   // start only from idle; a select still low in the tail waits its turn
   assign o_start = (state_q == IDLE) && !i_cs_n;
   assign o_write_edge = (state_q == ACCESS) && first_q && !read_q;
   assign o_access = (state_q == ACCESS);
   assign o_tail = (state_q == TAIL);
   assign o_finish = (state_q == TAIL);

   // sequence: select seen -> access until select high -> one tail edge
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q <= IDLE;
      end else if (i_clk_en) begin
         case (state_q)
            IDLE: begin
               if (!i_cs_n) begin
                  state_q <= ACCESS;
               end
            end
            ACCESS: begin
               if (i_cs_n) begin
                  state_q <= TAIL;
               end
            end
            TAIL: begin
               state_q <= IDLE;
            end
            default: begin
               state_q <= IDLE;
            end
         endcase
      end
   end

   // first access edge is the one write edge of a selection
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         first_q <= 1'b0;
         read_q <= 1'b1;
      end else if (i_clk_en) begin
         first_q <= o_start;
         if (o_start) begin
            read_q <= i_read;
         end
      end
   end
endmodule

// *** host_cpu_model.sv ***
// behavioural node processor driving the synchronous register port
`timescale 1ns/1ps
module host_cpu_model (
   input wire logic i_clk,
   input wire logic [host_port_pkg::DATA_W-1:0] i_dev_data,
   input wire logic i_dev_en_n,
   output logic o_cs_n,
   output logic [host_port_pkg::ADDR_W-1:0] o_addr,
   output logic o_read_write,
   output logic [host_port_pkg::DATA_W-1:0] o_bus
);
   import host_port_pkg::*;
   logic host_drive;
   logic [DATA_W-1:0] host_word;
   logic [DATA_W-1:0] last_q;
   // idle levels, no selection at time zero
   initial begin
      o_cs_n = 1'b1;
      o_read_write = 1'b1;
      o_addr = 5'h00;
      host_drive = 1'b0;
      host_word = 16'h0000;
      last_q = 16'h0000;
   end
   // a released bus shows the inverse of its last level, so stale data never matches
   always @(posedge i_clk) begin
      last_q <= o_bus;
   end
   assign o_bus = !i_dev_en_n ? i_dev_data : (host_drive ? host_word : ~last_q);
   // read: select, keep low for extra edges, sample at the first edge seeing deselect
   task automatic read_reg(input logic [4:0] a, input int hold, output logic [15:0] d);
      o_cs_n = 1'b0;
      o_read_write = 1'b1;
      o_addr = a;
      @(posedge i_clk);
      repeat (hold) @(posedge i_clk);
      #10;
      o_cs_n = 1'b1;
      @(posedge i_clk);
      d = o_bus;
      // tail edge must pass before a new selection
      repeat (2) @(posedge i_clk);
      #10;
   endtask
   // write: data valid from selection, held until two edges past deselect
   task automatic write_reg(input logic [4:0] a, input logic [15:0] d, input int hold);
      o_cs_n = 1'b0;
      o_read_write = 1'b0;
      o_addr = a;
      host_word = d;
      host_drive = 1'b1;
      repeat (2 + hold) @(posedge i_clk);
      #10;
      o_cs_n = 1'b1;
      repeat (2) @(posedge i_clk);
      #10;
      host_drive = 1'b0;
      o_read_write = 1'b1;
   endtask
endmodule

// *** tb_top.sv ***
// self-checking bench for the node processor register port
`timescale 1ns/1ps
module tb_top;
   import host_port_pkg::*;
   typedef struct packed {
      logic [4:0] addr;
      logic wr;
      logic [15:0] wdata;
      logic [15:0] exp;
   } row_t;
   logic i_clk, i_sys_rst, i_clk_en, scr_pin, cs_n, rw, en_n, irq_n, scr_on, unk;
   logic ptl_stb, ntl_stb;
   logic [4:0] addr;
   logic [3:0] conn_state;
   logic [2:0] count_inc;
   logic [15:0] bus, dout, sa, sb, ro_val, event_set, ctl_a, ctl_b, ctl_c, ptl, ntl;
   logic [15:0] last_ptl, last_ntl;
   int n_mismatch = 0;
   int compares = 0;
   int n_ptl = 0;
   int n_ntl = 0;
   int n0;
   row_t rows [16] = '{
      '{ADDR_CONTROL_A, 1'b1, 16'hffff, 16'h7fff}, '{ADDR_CONTROL_B, 1'b1, 16'ha5c3, 16'ha5c3},
      '{ADDR_INTERRUPT_ENABLE_MASK, 1'b1, 16'h8000, 16'h8000},
      '{ADDR_TRANSMIT_SIGNAL_BITS, 1'b1, 16'h1357, 16'h1357},
      '{ADDR_SIGNAL_BITS_COUNT, 1'b1, 16'h00ff, 16'h00ff}, '{ADDR_ERROR_LIMIT, 1'b1, 16'h0f0f, 16'h0f0f},
      '{ADDR_CONNECT_MIN_TIME, 1'b1, 16'h0001, 16'h0001}, '{ADDR_CONTROL_C, 1'b1, 16'h5a5b, 16'h5a5b},
      '{ADDR_CLEANUP_TIME, 1'b1, 16'h8001, 16'h8001}, '{ADDR_NOISE_LIMIT, 1'b1, 16'hfffe, 16'hfffe},
      '{ADDR_STATUS_A, 1'b0, 16'h0000, 16'h1234}, '{ADDR_PERIOD_TIMER_VALUE, 1'b0, 16'h0000, 16'hbeef},
      '{ADDR_NOISE_TIMER_VALUE, 1'b0, 16'h0000, 16'h4110},
      '{ADDR_CLOCK_DIVIDER_VALUE, 1'b0, 16'h0000, 16'hefbe},
      '{ADDR_PERIOD_TIMER_LOAD, 1'b0, 16'h0000, 16'h0000},
      '{ADDR_LINK_FAULT_COUNT, 1'b0, 16'h0000, 16'h0000}};

   node_processor_register_port u_node_processor_register_port (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_cs_n(cs_n),
      .i_host_address_bus(addr), .i_host_read_write(rw), .i_host_data_bus(bus),
      .o_host_data_bus(dout), .o_host_data_bus_en_n(en_n), .o_irq_n(irq_n),
      .i_scrambler_enable_pin(scr_pin), .o_scrambler_on(scr_on), .o_unknown_state_pin(unk),
      .i_conn_state(conn_state), .i_status_a(sa), .i_status_b(sb),
      .i_period_timer_value(ro_val), .i_noise_timer_value(~ro_val),
      .i_clock_divider_value({ro_val[7:0], ro_val[15:8]}), .i_self_test_result(ro_val ^ 16'h00ff),
      .i_received_signal_bits(ro_val), .i_event_set(event_set), .i_count_inc(count_inc),
      .o_control_a(ctl_a), .o_control_b(ctl_b), .o_control_c(ctl_c),
      .o_period_timer_load(ptl), .o_period_timer_load_stb(ptl_stb),
      .o_noise_timer_load(ntl), .o_noise_timer_load_stb(ntl_stb));
   host_cpu_model u_host_cpu_model (
      .i_clk(i_clk), .i_dev_data(dout), .i_dev_en_n(en_n), .o_cs_n(cs_n), .o_addr(addr),
      .o_read_write(rw), .o_bus(bus));

   // 10 MHz port clock
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   // count load strobes so a doubled write cannot hide
   always @(posedge i_clk) begin
      if (ptl_stb === 1'b1) begin
         n_ptl++;
         last_ptl = ptl;
      end
      if (ntl_stb === 1'b1) begin
         n_ntl++;
         last_ntl = ntl;
      end
   end
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %b want %b", $time, what, got, exp);
      end
   endtask
   // read through the host model, then the bus must be released again
   task automatic rd_chk(input logic [4:0] a, input int hold, input logic [15:0] exp);
      logic [15:0] d;
      u_host_cpu_model.read_reg(a, hold, d);
      chk16(d, exp, "read data");
      chk1(en_n, 1'b1, "bus released after read");
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d, input int hold);
      u_host_cpu_model.write_reg(a, d, hold);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge i_clk);
      #10;
   endtask
   task automatic complete_run;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // watchdog well past the test length
   initial begin
      #(5000 * 100);
      n_mismatch++;
      complete_run();
   end
   initial begin
      i_sys_rst = 1'b1;
      i_clk_en = 1'b1;
      scr_pin = 1'b0;
      conn_state = CONN_OFF;
      sa = 16'h1234;
      sb = 16'h0000;
      ro_val = 16'hbeef;
      event_set = 16'h0000;
      count_inc = 3'h0;
      settle(20);
      i_sys_rst = 1'b0;
      chk1(en_n, 1'b1, "bus idle after reset");
      chk1(irq_n, 1'b1, "irq idle after reset");
      chk16(ctl_a, ZERO_WORD, "control_a reset");
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].addr, rows[i].wdata, 0);
         rd_chk(rows[i].addr, 0, rows[i].exp);
      end
      chk16(ctl_b, 16'ha5c3, "control_b pins");
      chk16(ctl_c, 16'h5a5b, "control_c pins");
      // guarded control_a bits hold outside off and service states
      conn_state = 4'h3;
      wr(ADDR_CONTROL_A, ZERO_WORD, 0);
      rd_chk(ADDR_CONTROL_A, 0, 16'h3000);
      chk16(ctl_a, 16'h3000, "control_a pins");
      // refused writes: read-only, unmapped, vector during signalling
      wr(ADDR_STATUS_A, FULL_WORD, 0);
      rd_chk(ADDR_STATUS_A, 0, 16'h1234);
      rd_chk(ADDR_EVENT_FLAGS, 0, ONE_WORD);
      rd_chk(ADDR_EVENT_FLAGS, 0, ZERO_WORD);
      wr(5'h1f, FULL_WORD, 0);
      rd_chk(ADDR_EVENT_FLAGS, 0, ONE_WORD);
      sb = 16'h0100;
      wr(ADDR_TRANSMIT_SIGNAL_BITS, ZERO_WORD, 0);
      rd_chk(ADDR_TRANSMIT_SIGNAL_BITS, 0, 16'h1357);
      rd_chk(ADDR_EVENT_FLAGS, 0, ONE_WORD);
      sb = 16'h0000;
      // timer loads: refused outside service, once per selection inside
      n0 = n_ptl;
      wr(ADDR_PERIOD_TIMER_LOAD, 16'h0abc, 0);
      chk16(16'(n_ptl - n0), ZERO_WORD, "period load refused");
      rd_chk(ADDR_EVENT_FLAGS, 0, ONE_WORD);
      conn_state = CONN_SERVICE;
      wr(ADDR_PERIOD_TIMER_LOAD, 16'h0abc, 4);
      chk16(16'(n_ptl - n0), ONE_WORD, "one load per selection");
      chk16(last_ptl, 16'h0abc, "period load value");
      wr(ADDR_CONTROL_A, 16'h4000, 0);
      n0 = n_ntl;
      wr(ADDR_NOISE_TIMER_LOAD, 16'h0123, 0);
      chk16(16'(n_ntl - n0), ZERO_WORD, "noise load refused");
      rd_chk(ADDR_EVENT_FLAGS, 0, ONE_WORD);
      wr(ADDR_CONTROL_A, ZERO_WORD, 0);
      wr(ADDR_NOISE_TIMER_LOAD, 16'h0123, 0);
      chk16(last_ntl, 16'h0123, "noise load value");
      chk16(16'(n_ntl - n0), ONE_WORD, "noise load count");
      // interrupt stays low until the event flags are read
      wr(ADDR_INTERRUPT_ENABLE_MASK, ONE_WORD, 0);
      wr(ADDR_STATUS_B, FULL_WORD, 0);
      settle(6);
      chk1(irq_n, 1'b0, "irq held low");
      rd_chk(ADDR_EVENT_FLAGS, 0, ONE_WORD);
      settle(2);
      chk1(irq_n, 1'b1, "irq cleared by read");
      // clear-on-read counters and event flags
      for (int k = 0; k < 3; k++) begin
         count_inc = 3'(1 << k);
         settle(3);
         count_inc = 3'h0;
         rd_chk(5'(ADDR_BAD_SYMBOL_COUNT + k), 0, 16'h0003);
         rd_chk(5'(ADDR_BAD_SYMBOL_COUNT + k), 0, ZERO_WORD);
      end
      event_set = 16'h0020;
      settle(1);
      event_set = 16'h0000;
      rd_chk(ADDR_EVENT_FLAGS, 0, 16'h0020);
      rd_chk(ADDR_EVENT_FLAGS, 0, ZERO_WORD);
      // long selection keeps the data on the bus
      rd_chk(ADDR_CONTROL_B, 5, 16'ha5c3);
      // pins: unknown-state copy and scrambler selection
      sa = 16'h0100;
      settle(3);
      chk1(unk, 1'b1, "unknown state pin high");
      sa = 16'h1234;
      settle(3);
      chk1(unk, 1'b0, "unknown state pin low");
      settle(4);
      chk1(scr_on, 1'b1, "scrambler by control_c");
      wr(ADDR_CONTROL_C, ZERO_WORD, 0);
      settle(4);
      chk1(scr_on, 1'b0, "scrambler off");
      scr_pin = 1'b1;
      settle(4);
      chk1(scr_on, 1'b1, "scrambler by pin");
      // enable low: increments are ignored
      {i_clk_en, count_inc} = 4'h7;
      settle(2);
      {i_clk_en, count_inc} = 4'h8;
      rd_chk(ADDR_LINK_FAULT_COUNT, 0, ZERO_WORD);
      wr(ADDR_CONTROL_A, CONTROL_A_USED, 0);
      // second reset in mid-run clears control_a again
      i_sys_rst = 1'b1;
      settle(20);
      i_sys_rst = 1'b0;
      chk16(ctl_a, ZERO_WORD, "control_a after reset");
      rd_chk(ADDR_CONTROL_A, 0, ZERO_WORD);
      complete_run();
   end
endmodule
